// >>> include/pms_defines.svh
// Constants of the management port and start-up sequencer.
// Included by the package and the simulation files; defines only.
`ifndef PMS_DEFINES_SVH
`define PMS_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PMS_CLK_PERIOD_NS 100
`define PMS_READY_US      300
`define PMS_READY_CYCLES  ((`PMS_READY_US * 1000) / `PMS_CLK_PERIOD_NS)
`define PMS_PREAMBLE_BITS 6'h20

// ----------------------------------------
// Frame fields
// ----------------------------------------
`define PMS_OP_READ  2'h2
`define PMS_OP_WRITE 2'h1
`define PMS_HDR_LAST 4'hB
`define PMS_DATA_LAST 4'hF

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define PMS_ADDR_CONTROL     5'h00
`define PMS_ADDR_STATUS_BAS  5'h01
`define PMS_ADDR_ID_HIGH     5'h02
`define PMS_ADDR_ID_LOW      5'h03
`define PMS_ADDR_LOCAL_ABIL  5'h04
`define PMS_ADDR_PART_BASE   5'h05
`define PMS_ADDR_EXPANSION   5'h06
`define PMS_ADDR_NP_OUT      5'h07
`define PMS_ADDR_NP_IN       5'h08
`define PMS_ADDR_GIG_CTRL    5'h09
`define PMS_ADDR_GIG_STAT    5'h0A
`define PMS_ADDR_EXT_STAT    5'h0F
`define PMS_ADDR_PORT_SETUP  5'h10
`define PMS_ADDR_STATUS_EXT  5'h11
`define PMS_ADDR_IRQ_MASK    5'h12
`define PMS_ADDR_IRQ_FLAGS   5'h13
`define PMS_ADDR_IND_SETUP   5'h14

// ----------------------------------------
// Reset values of writable words
// ----------------------------------------
`define PMS_RST_CONTROL    16'h0000
`define PMS_RST_LOCAL_ABIL 16'h0001
`define PMS_RST_NP_OUT     16'h0000
`define PMS_RST_PORT_SETUP 16'h0000
`define PMS_RST_IRQ_MASK   16'h0000
`define PMS_RST_IND_SETUP  16'h0000

`endif

// >>> include/pms_pkg.sv
// Types and address decoding for the management port.
// Assumes pms_defines.svh on the include path.
`include "pms_defines.svh"

package pms_pkg;

    typedef logic [15:0] pms_word_t;
    typedef logic [4:0]  pms_addr_t;
    typedef logic [2:0]  pms_slot_t;

    typedef enum logic [5:0] {
        PMS_ST_IDLE  = 6'h01,
        PMS_ST_START = 6'h02,
        PMS_ST_HDR   = 6'h04,
        PMS_ST_TA    = 6'h08,
        PMS_ST_DATA  = 6'h10,
        PMS_ST_SKIP  = 6'h20
    } pms_state_t;

    // Maps an address to a writable slot; bit 3 flags a hit
    function automatic logic [3:0] pms_slot(input pms_addr_t addr);
        logic [3:0] r;
        r = 4'h0;
        unique case (addr)
            `PMS_ADDR_CONTROL:    r = 4'h8;
            `PMS_ADDR_LOCAL_ABIL: r = 4'h9;
            `PMS_ADDR_NP_OUT:     r = 4'hA;
            `PMS_ADDR_PORT_SETUP: r = 4'hB;
            `PMS_ADDR_IRQ_MASK:   r = 4'hC;
            `PMS_ADDR_IND_SETUP:  r = 4'hD;
            default:              r = 4'h0;
        endcase
        return r;
    endfunction

endpackage

// >>> core/pms_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs change slowly against the clock.
`timescale 1ns/1ps
`default_nettype none

module pms_sync (
    input  wire logic       clock,
    input  wire logic       arst_n,
    input  wire logic       ce,
    input  wire logic [1:0] raw_in,
    output logic      [1:0] clean_q
);
    import pms_pkg::*;

    logic [1:0] st1_q, st2_q, st3_q;
    logic [1:0] st1_d, st2_d, st3_d, clean_d;

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_bit
            always_comb begin
                st1_d[i]   = raw_in[i];
                st2_d[i]   = st1_q[i];
                st3_d[i]   = st2_q[i];
                clean_d[i] = (st2_q[i] == st3_q[i]) ? st3_q[i] : clean_q[i];
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st1_q   <= 2'h0;
            st2_q   <= 2'h0;
            st3_q   <= 2'h0;
            clean_q <= 2'h0;
        end else if (ce) begin
            st1_q   <= st1_d;
            st2_q   <= st2_d;
            st3_q   <= st3_d;
            clean_q <= clean_d;
        end
    end

endmodule

`default_nettype wire

// >>> core/pms_regfile.sv
// Writable management words with a registered read port.
// Assumes writes and reads come from the frame engine on one clock.
`timescale 1ns/1ps
`default_nettype none

module pms_regfile (
    input  wire logic               clock,
    input  wire logic               arst_n,
    input  wire logic               ce,
    input  wire logic               wr_en,
    input  wire pms_pkg::pms_slot_t wr_slot,
    input  wire pms_pkg::pms_word_t wr_data,
    input  wire pms_pkg::pms_slot_t rd_slot,
    output pms_pkg::pms_word_t      rd_data_q,
    output pms_pkg::pms_word_t      word0_q,
    output pms_pkg::pms_word_t      word1_q,
    output pms_pkg::pms_word_t      word2_q,
    output pms_pkg::pms_word_t      word3_q,
    output pms_pkg::pms_word_t      word4_q,
    output pms_pkg::pms_word_t      word5_q
);
    import pms_pkg::*;

    function automatic pms_word_t rst_val(input int idx);
        pms_word_t v;
        v = `PMS_RST_CONTROL;
        case (idx)
            1:       v = `PMS_RST_LOCAL_ABIL;
            2:       v = `PMS_RST_NP_OUT;
            3:       v = `PMS_RST_PORT_SETUP;
            4:       v = `PMS_RST_IRQ_MASK;
            5:       v = `PMS_RST_IND_SETUP;
            default: v = `PMS_RST_CONTROL;
        endcase
        return v;
    endfunction

    pms_word_t mem_q [6];
    pms_word_t mem_d [6];
    pms_word_t rd_data_d;

    genvar i;
    generate
        for (i = 0; i < 6; i++) begin : g_word
            always_comb begin
                mem_d[i] = (wr_en && wr_slot == 3'(i)) ? wr_data : mem_q[i];
            end
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    mem_q[i] <= rst_val(i);
                end else if (ce) begin
                    mem_q[i] <= mem_d[i];
                end
            end
        end
    endgenerate

    always_comb begin
        rd_data_d = (rd_slot < 3'h6) ? mem_q[rd_slot] : 16'h0000;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_q <= 16'h0000;
        end else if (ce) begin
            rd_data_q <= rd_data_d;
        end
    end

    assign word0_q = mem_q[0];
    assign word1_q = mem_q[1];
    assign word2_q = mem_q[2];
    assign word3_q = mem_q[3];
    assign word4_q = mem_q[4];
    assign word5_q = mem_q[5];

endmodule

`default_nettype wire

// >>> core/pms_top.sv
// Management serial slave and start-up sequencer of a 10/100 transceiver.
// Assumes management clock and data arrive as pins; status words from
// the line-side logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module pms_top #(
    parameter logic [15:0] ID_HIGH = 16'h0A5A, // Arbitrary value
    parameter logic [15:0] ID_LOW  = 16'h5C31  // Arbitrary value
) (
    input  wire logic               clock,
    input  wire logic               arst_n,
    input  wire logic               ce,
    input  wire logic               mdc,
    input  wire logic               mdio_in,
    output logic                    mdio_out_q,
    output logic                    mdio_oe_n_q,
    input  wire pms_pkg::pms_addr_t phy_addr,
    output logic                    mgmt_ready_q,
    input  wire pms_pkg::pms_word_t status_basic,
    input  wire pms_pkg::pms_word_t partner_base,
    input  wire pms_pkg::pms_word_t expansion,
    input  wire pms_pkg::pms_word_t np_incoming,
    input  wire pms_pkg::pms_word_t status_extra,
    input  wire pms_pkg::pms_word_t irq_flags_in,
    output pms_pkg::pms_word_t      control_word,
    output pms_pkg::pms_word_t      local_ability_word,
    output pms_pkg::pms_word_t      np_outgoing_word,
    output pms_pkg::pms_word_t      port_setup_word,
    output pms_pkg::pms_word_t      irq_mask_word,
    output pms_pkg::pms_word_t      indicator_word
);
    import pms_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] pins_clean;
    logic       mdc_s;
    logic       mdio_s;

    pms_sync u_sync (
        .clock   (clock),
        .arst_n  (arst_n),
        .ce      (ce),
        .raw_in  ({mdc, mdio_in}),
        .clean_q (pins_clean)
    );

    assign mdc_s  = pins_clean[1];
    assign mdio_s = pins_clean[0];

    // ----------------------------------------
    // Start-up sequencer
    // ----------------------------------------
    logic [11:0] ready_cnt_q, ready_cnt_d;
    logic        ready_d;
    logic        strap_q, strap_d;
    pms_addr_t   phy_q, phy_d;

    always_comb begin
        ready_cnt_d = ready_cnt_q;
        ready_d     = mgmt_ready_q;
        if (!mgmt_ready_q) begin
            if (ready_cnt_q == 12'(`PMS_READY_CYCLES - 1)) begin
                ready_d = 1'b1;
            end else begin
                ready_cnt_d = ready_cnt_q + 12'h001;
            end
        end
        strap_d = 1'b1;
        phy_d   = strap_q ? phy_q : phy_addr;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ready_cnt_q  <= 12'h000;
            mgmt_ready_q <= 1'b0;
            strap_q      <= 1'b0;
            phy_q        <= 5'h00;
        end else if (ce) begin
            ready_cnt_q  <= ready_cnt_d;
            mgmt_ready_q <= ready_d;
            strap_q      <= strap_d;
            phy_q        <= phy_d;
        end
    end

    // ----------------------------------------
    // Frame engine
    // ----------------------------------------
    pms_state_t  state_q, state_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [5:0]  ones_q, ones_d;
    logic [11:0] hdr_q, hdr_d;
    pms_word_t   shift_q, shift_d;
    logic        hit_q, hit_d;
    logic        rd_q, rd_d;
    logic        mdc_prev_q, mdc_prev_d;
    logic        out_d, oe_n_d;
    logic        rise;
    logic [11:0] hdr_full;
    logic        rf_wr_en;
    pms_word_t   rf_wr_data;
    pms_word_t   rf_rd_q;
    pms_word_t   read_word;
    logic [3:0]  wr_map;
    logic        read_load;

    // Edge found from a slow management clock
    assign rise      = mdc_s && !mdc_prev_q;
    assign hdr_full  = {hdr_q[10:0], mdio_s};
    assign read_load = rise && (state_q == PMS_ST_TA) && (cnt_q == 4'h0);
    assign wr_map    = pms_slot(hdr_q[4:0]);

    always_comb begin
        read_word = 16'h0000;
        if (pms_slot(hdr_q[4:0]) != 4'h0) begin
            read_word = rf_rd_q;
        end else begin
            unique case (hdr_q[4:0])
                `PMS_ADDR_STATUS_BAS: read_word = status_basic;
                `PMS_ADDR_ID_HIGH:    read_word = ID_HIGH;
                `PMS_ADDR_ID_LOW:     read_word = ID_LOW;
                `PMS_ADDR_PART_BASE:  read_word = partner_base;
                `PMS_ADDR_EXPANSION:  read_word = expansion;
                `PMS_ADDR_NP_IN:      read_word = np_incoming;
                `PMS_ADDR_STATUS_EXT: read_word = status_extra;
                `PMS_ADDR_IRQ_FLAGS:  read_word = irq_flags_in;
                default:              read_word = 16'h0000;
            endcase
        end
    end

    always_comb begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        ones_d     = ones_q;
        hdr_d      = hdr_q;
        shift_d    = shift_q;
        hit_d      = hit_q;
        rd_d       = rd_q;
        out_d      = mdio_out_q;
        oe_n_d     = mdio_oe_n_q;
        rf_wr_en   = 1'b0;
        rf_wr_data = {shift_q[14:0], mdio_s};
        mdc_prev_d = mdc_s;
        if (rise) begin
            unique case (state_q)
                PMS_ST_IDLE: begin
                    if (mdio_s) begin
                        if (ones_q != `PMS_PREAMBLE_BITS) begin
                            ones_d = ones_q + 6'h01;
                        end
                    end else begin
                        ones_d  = 6'h00;
                        state_d = (ones_q == `PMS_PREAMBLE_BITS) ? PMS_ST_START : PMS_ST_IDLE;
                    end
                end
                PMS_ST_START: begin
                    cnt_d   = 4'h0;
                    state_d = mdio_s ? PMS_ST_HDR : PMS_ST_IDLE;
                end
                PMS_ST_HDR: begin
                    hdr_d = hdr_full;
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == `PMS_HDR_LAST) begin
                        // Busy or foreign frames are sat out silently
                        hit_d   = mgmt_ready_q && (hdr_full[9:5] == phy_q) &&
                                  ((hdr_full[11:10] == `PMS_OP_READ) ||
                                   (hdr_full[11:10] == `PMS_OP_WRITE));
                        rd_d    = (hdr_full[11:10] == `PMS_OP_READ);
                        cnt_d   = 4'h0;
                        state_d = PMS_ST_TA;
                    end
                end
                PMS_ST_TA: begin
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == 4'h0) begin
                        shift_d = read_word;
                        if (hit_q && rd_q) begin
                            oe_n_d = 1'b0;
                            out_d  = 1'b0;
                        end
                    end else begin
                        shift_d = {shift_q[14:0], mdio_s};
                        out_d   = hit_q && rd_q && shift_q[15];
                        cnt_d   = 4'h0;
                        state_d = PMS_ST_DATA;
                    end
                end
                PMS_ST_DATA: begin
                    shift_d = {shift_q[14:0], mdio_s};
                    cnt_d   = cnt_q + 4'h1;
                    if (hit_q && rd_q) begin
                        out_d = shift_q[15];
                    end
                    if (cnt_q == `PMS_DATA_LAST) begin
                        rf_wr_en = hit_q && !rd_q && wr_map[3];
                        oe_n_d   = 1'b1;
                        out_d    = 1'b0;
                        cnt_d    = 4'h0;
                        state_d  = PMS_ST_IDLE;
                    end
                end
                default: begin
                    oe_n_d  = 1'b1;
                    out_d   = 1'b0;
                    state_d = PMS_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q     <= PMS_ST_IDLE;
            cnt_q       <= 4'h0;
            ones_q      <= 6'h00;
            hdr_q       <= 12'h000;
            shift_q     <= 16'h0000;
            hit_q       <= 1'b0;
            rd_q        <= 1'b0;
            mdc_prev_q  <= 1'b0;
            mdio_out_q  <= 1'b0;
            mdio_oe_n_q <= 1'b1;
        end else if (ce) begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            ones_q      <= ones_d;
            hdr_q       <= hdr_d;
            shift_q     <= shift_d;
            hit_q       <= hit_d;
            rd_q        <= rd_d;
            mdc_prev_q  <= mdc_prev_d;
            mdio_out_q  <= out_d;
            mdio_oe_n_q <= oe_n_d;
        end
    end

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    pms_regfile u_regs (
        .clock     (clock),
        .arst_n    (arst_n),
        .ce        (ce),
        .wr_en     (rf_wr_en),
        .wr_slot   (wr_map[2:0]),
        .wr_data   (rf_wr_data),
        .rd_slot   (wr_map[2:0]),
        .rd_data_q (rf_rd_q),
        .word0_q   (control_word),
        .word1_q   (local_ability_word),
        .word2_q   (np_outgoing_word),
        .word3_q   (port_setup_word),
        .word4_q   (irq_mask_word),
        .word5_q   (indicator_word)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [11:0] since_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            since_q <= 12'h000;
        end else if (ce && since_q != 12'hFFF) begin
            since_q <= since_q + 12'h001;
        end
    end

    chk_ready_late: assert property (@(posedge clock) disable iff (!arst_n)
        !mgmt_ready_q |-> since_q < 12'(`PMS_READY_CYCLES))
        else $error("port not ready in time");

    chk_ready_early: assert property (@(posedge clock) disable iff (!arst_n)
        mgmt_ready_q |-> since_q >= 12'(`PMS_READY_CYCLES))
        else $error("port ready too early");

    chk_busy_quiet: assert property (@(posedge clock) disable iff (!arst_n)
        !mgmt_ready_q |-> mdio_oe_n_q && !rf_wr_en)
        else $error("port active before ready");

    chk_word_whole: assert property (@(posedge clock) disable iff (!arst_n)
        rf_wr_en |-> state_q == PMS_ST_DATA && cnt_q == `PMS_DATA_LAST && !rd_q)
        else $error("write not after sixteen bits");

    chk_ctrl_write: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && rf_wr_en && hdr_q[4:0] == `PMS_ADDR_CONTROL)
        |=> control_word == $past(rf_wr_data))
        else $error("control word not written");

    chk_id_read: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && read_load && hdr_q[4:0] == `PMS_ADDR_ID_HIGH) |=> shift_q == ID_HIGH)
        else $error("identifier high half wrong");

    chk_base_read: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && read_load && hdr_q[4:0] == `PMS_ADDR_PART_BASE)
        |=> shift_q == $past(partner_base))
        else $error("partner base word wrong");

    chk_np_write: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && rf_wr_en && hdr_q[4:0] == `PMS_ADDR_NP_OUT)
        |=> np_outgoing_word == $past(rf_wr_data))
        else $error("next page word not written");

    chk_np_read: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && read_load && hdr_q[4:0] == `PMS_ADDR_NP_IN)
        |=> shift_q == $past(np_incoming))
        else $error("received next page wrong");

    chk_unimpl_zero: assert property (@(posedge clock) disable iff (!arst_n)
        (ce && read_load && (hdr_q[4:0] == `PMS_ADDR_GIG_CTRL ||
         hdr_q[4:0] == `PMS_ADDR_GIG_STAT || hdr_q[4:0] == `PMS_ADDR_EXT_STAT))
        |=> shift_q == 16'h0000 && $stable(control_word))
        else $error("unimplemented address not zero");

endmodule

`default_nettype wire

// >>> sim/pms_station.sv
// Station manager model driving the management clock and data pins.
// Assumes a 100 ns system clock; an undriven data pin is pulled up.
`timescale 1ns/1ps
`default_nettype none
`include "pms_defines.svh"

module pms_station (
    input  wire logic clock,
    input  wire logic mdio_out_q,
    input  wire logic mdio_oe_n_q,
    output logic      mdc,
    output logic      mdio_in
);
    logic drv;

    // Pin level: device when enabled, else station or pull-up
    assign mdio_in = !mdio_oe_n_q ? mdio_out_q : drv;

    initial begin
        mdc = 1'b0;
        drv = 1'b1;
    end

    // One whole frame; clock stands low between frames
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] reg_a, input logic [15:0] wdata,
                         output logic [15:0] rdata);
        logic [63:0] bits;
        bits = {32'hFFFFFFFF, 2'b01, op, phy, reg_a, 2'b10, wdata};
        if (op == `PMS_OP_READ) begin
            bits[17:0] = 18'h3FFFF;
        end
        rdata = 16'h0000;
        @(posedge clock);
        for (int i = 0; i < 64; i++) begin
            drv <= bits[63-i];
            repeat (4) @(posedge clock);
            if (i >= 48) begin
                rdata[63-i] = mdio_in;
            end
            mdc <= 1'b1;
            repeat (4) @(posedge clock);
            mdc <= 1'b0;
        end
        @(posedge clock) drv <= 1'b1;
    endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Testbench of the management port and start-up sequencer.
// Assumes pms_pkg and pms_station compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "pms_defines.svh"

module testbench;
    import pms_pkg::*;
    localparam logic [15:0] ID_H = 16'h1B2C; // Arbitrary value
    localparam logic [15:0] ID_L = 16'h3D4E; // Arbitrary value
    logic      clock, arst_n, mdc, mdio_in, mdio_out_q, mdio_oe_n_q, mgmt_ready_q;
    pms_word_t status_basic, partner_base, expansion, np_incoming, status_extra;
    pms_word_t irq_flags_in, control_word, local_ability_word, np_outgoing_word;
    pms_word_t port_setup_word, irq_mask_word, indicator_word, rd;
    int        miscompares, n_checks, cycles;
    pms_addr_t ra [8];
    pms_word_t rx [8];

    pms_top #(.ID_HIGH(ID_H), .ID_LOW(ID_L)) i_pms_top (
        .clock, .arst_n, .ce(1'b1), .mdc, .mdio_in, .mdio_out_q, .mdio_oe_n_q,
        .phy_addr(5'h03), .mgmt_ready_q, .status_basic, .partner_base, .expansion,
        .np_incoming, .status_extra, .irq_flags_in, .control_word,
        .local_ability_word, .np_outgoing_word, .port_setup_word, .irq_mask_word,
        .indicator_word);

    pms_station i_pms_station (.clock, .mdio_out_q, .mdio_oe_n_q, .mdc, .mdio_in);

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic mread(input pms_addr_t a, output pms_word_t d);
        i_pms_station.frame(`PMS_OP_READ, 5'h03, a, 16'h0000, d);
    endtask

    task automatic mwrite(input pms_addr_t a, input pms_word_t d);
        pms_word_t unused;
        i_pms_station.frame(`PMS_OP_WRITE, 5'h03, a, d, unused);
    endtask

    task automatic do_reset;
        int n;
        n = 0;
        @(posedge clock) arst_n <= 1'b0;
        repeat (5) @(posedge clock);
        chk("oe_n in reset", 16'h0001, 16'(mdio_oe_n_q));
        chk("ability reset", `PMS_RST_LOCAL_ABIL, local_ability_word);
        chk("np_out reset", `PMS_RST_NP_OUT, np_outgoing_word);
        arst_n <= 1'b1;
        while (mgmt_ready_q !== 1'b1 && n < 4000) begin
            @(negedge clock);
            n++;
        end
        chk("ready in time", 16'h0001, 16'(n <= `PMS_READY_CYCLES + 1));
        repeat (10) @(posedge clock);
    endtask

    task automatic complete_run;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            complete_run();
        end
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        arst_n       = 1'b0;
        status_basic = 16'h7849;
        partner_base = 16'h45E1;
        expansion    = 16'h0003;
        np_incoming  = 16'h2801;
        status_extra = 16'h0C10;
        irq_flags_in = 16'h00A4;
        do_reset();
        $display("test power-up done");
        ra = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h11, 5'h13};
        rx = '{16'h7849, ID_H, ID_L, 16'h45E1, 16'h0003, 16'h2801, 16'h0C10, 16'h00A4};
        for (int i = 0; i < 8; i++) begin
            mread(ra[i], rd);
            chk("read word", rx[i], rd);
        end
        @(posedge clock) partner_base <= 16'hC3A5;
        mread(5'h05, rd);
        chk("partner base", 16'hC3A5, rd);
        $display("test reads done");
        mwrite(5'h07, 16'hA5C3);
        @(posedge clock);
        chk("np_out word", 16'hA5C3, np_outgoing_word);
        mread(5'h07, rd);
        chk("np_out read", 16'hA5C3, rd);
        mwrite(5'h00, 16'h1234);
        mwrite(5'h04, 16'h01E1);
        mwrite(5'h10, 16'h0C5A);
        mwrite(5'h12, 16'h00F2);
        mwrite(5'h14, 16'h0321);
        @(posedge clock);
        chk("control word", 16'h1234, control_word);
        chk("ability word", 16'h01E1, local_ability_word);
        chk("port setup word", 16'h0C5A, port_setup_word);
        chk("irq mask word", 16'h00F2, irq_mask_word);
        chk("indicator word", 16'h0321, indicator_word);
        mread(5'h00, rd);
        chk("control read", 16'h1234, rd);
        mread(5'h14, rd);
        chk("indicator read", 16'h0321, rd);
        ra[0] = 5'h09;
        ra[1] = 5'h0A;
        ra[2] = 5'h0F;
        for (int i = 0; i < 3; i++) begin
            mwrite(ra[i], 16'hFFFF);
            mread(ra[i], rd);
            chk("unused word", 16'h0000, rd);
        end
        @(posedge clock);
        chk("control kept", 16'h1234, control_word);
        chk("np_out kept", 16'hA5C3, np_outgoing_word);
        $display("test writes done");
        do_reset();
        mread(5'h07, rd);
        chk("np_out after reset", `PMS_RST_NP_OUT, rd);
        $display("test second reset done");
        complete_run();
    end
endmodule
`default_nettype wire
